/* rtl/ueh_pkg.sv */
/*
 * Package for the endpoint handshake status block: register offsets,
 * status bit positions, reset values and the event structs exchanged
 * with the serial engine.
 * Assumes a 32-bit APB slave and a fixed count of endpoints.
 */
package ueh_pkg;
    // ==========================================================
    // Sizes
    localparam int unsigned NUM_EP = 6;
    localparam int unsigned EP_W = 3;

    // ==========================================================
    // Register map (byte addresses)
    // Status registers, one word per endpoint from this base
    localparam logic [11:0] OFS_EP_STATUS = 12'h000;
    // Per-endpoint type bits: bit 0 control, bit 1 isochronous
    localparam logic [11:0] OFS_EP_TYPE = 12'h040;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h080;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h084;
    localparam logic [11:0] OFS_EP_END = 12'h018;

    // ==========================================================
    // Status and type bit positions
    localparam int unsigned BIT_OUT_B1 = 6;
    localparam int unsigned BIT_STALL_RQ = 5;
    localparam int unsigned BIT_IN_RDY = 4;
    localparam int unsigned BIT_STALL_SENT = 3;
    localparam int unsigned BIT_SETUP = 2;
    localparam int unsigned TYPE_CTRL = 0;
    localparam int unsigned TYPE_ISO = 1;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_EP_STATUS = 8'h00;
    localparam logic [1:0] RST_EP_TYPE = 2'h0;
    localparam logic [5:0] RST_IRQ = 6'h00;

    // Events and queries from the serial engine, one endpoint at a time
    typedef struct packed {
        logic out_b1_stored;
        logic setup_valid;
        logic in_acked;
        logic stall_sent;
        logic [2:0] ep;
    } ueh_sie_evt_s;

    // Handshake decision returned for the queried endpoint
    typedef struct packed {
        logic reject_out_b1;
        logic send_stall;
        logic in_ready;
        logic send_zlp;
    } ueh_hs_s;
endpackage

/* rtl/ueh_status.sv */
/*
 * Endpoint handshake status registers with APB access and interrupt.
 * Holds per-endpoint bank-1 OUT, stall request, IN ready, stall sent
 * and SETUP flags; answers the serial engine's handshake queries.
 * Assumes the serial engine runs on pclk and sends one-cycle events.
 */
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module ueh_status (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ueh_pkg::ueh_sie_evt_s sie_evt,
    input wire logic [2:0] query_ep,
    input wire logic fifo_empty,
    output ueh_pkg::ueh_hs_s hs,
    output logic irq
);
    // ==========================================================
    // Storage
    logic [7:0] ep_status_ff [ueh_pkg::NUM_EP];
    logic [1:0] ep_type_ff [ueh_pkg::NUM_EP];
    logic [5:0] irq_status_ff;
    logic [5:0] irq_mask_ff;
    logic [31:0] prdata_ff;
    logic wr_en;
    logic rd_en;
    logic ep_sel;
    logic [2:0] ep_idx;
    logic [5:0] evt_ep_hot;

    // Word index of a status or type address, when in range
    function automatic logic [2:0] ep_of(input logic [11:0] a, input logic [11:0] base);
        logic [11:0] d;
        d = a - base;
        return d[4:2];
    endfunction

    function automatic logic in_ep_range(input logic [11:0] a, input logic [11:0] base);
        return (a >= base) && (a < base + ueh_pkg::OFS_EP_END) && (a[1:0] == 2'b00);
    endfunction

    // ==========================================================
    // APB decode; zero wait states, unmapped reads zero with error
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign ep_sel = in_ep_range(paddr, ueh_pkg::OFS_EP_STATUS);
    assign ep_idx = ep_sel ? ep_of(paddr, ueh_pkg::OFS_EP_STATUS)
                           : ep_of(paddr, ueh_pkg::OFS_EP_TYPE);

    // Error for addresses outside the map
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable && !ep_sel && !in_ep_range(paddr, ueh_pkg::OFS_EP_TYPE) &&
            paddr != ueh_pkg::OFS_IRQ_STATUS && paddr != ueh_pkg::OFS_IRQ_MASK) begin
            pslverr = 1'b1;
        end
    end

    // Read data latched in setup so it is steady through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata_ff <= 32'h0000_0000;
            if (ep_sel) begin
                prdata_ff <= {24'h00_0000, ep_status_ff[ep_idx]};
            end else if (in_ep_range(paddr, ueh_pkg::OFS_EP_TYPE)) begin
                prdata_ff <= {30'h0000_0000, ep_type_ff[ep_idx]};
            end else if (paddr == ueh_pkg::OFS_IRQ_STATUS) begin
                prdata_ff <= {26'h000_0000, irq_status_ff};
            end else if (paddr == ueh_pkg::OFS_IRQ_MASK) begin
                prdata_ff <= {26'h000_0000, irq_mask_ff};
            end
        end
    end
    assign prdata = prdata_ff;

    // ==========================================================
    // Status bits, one copy per endpoint
    // Hardware set wins over a firmware clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < ueh_pkg::NUM_EP; i++) begin
                ep_status_ff[i] <= ueh_pkg::RST_EP_STATUS;
                ep_type_ff[i] <= ueh_pkg::RST_EP_TYPE;
            end
        end else begin
            for (int i = 0; i < ueh_pkg::NUM_EP; i++) begin
                logic [7:0] nxt_st;
                logic hit;
                nxt_st = ep_status_ff[i];
                hit = (sie_evt.ep == i[2:0]);
                // Firmware write of the low byte; loads bank-one flag from pwdata like the rest
                if (wr_en && ep_sel && pstrb[0] && ep_idx == i[2:0]) begin
                    nxt_st = pwdata[7:0];
                end
                if (wr_en && !ep_sel && pstrb[0] && ep_idx == i[2:0] &&
                    in_ep_range(paddr, ueh_pkg::OFS_EP_TYPE)) begin
                    ep_type_ff[i] <= pwdata[1:0];
                end
                if (hit) begin
                    if (sie_evt.out_b1_stored) begin
                        nxt_st[ueh_pkg::BIT_OUT_B1] = 1'b1;
                    end
                    if (sie_evt.in_acked) begin
                        nxt_st[ueh_pkg::BIT_IN_RDY] = 1'b0;
                    end
                    if (sie_evt.stall_sent && !ep_type_ff[i][ueh_pkg::TYPE_ISO]) begin
                        nxt_st[ueh_pkg::BIT_STALL_SENT] = 1'b1;
                    end
                    // SETUP clears others, drops stall request
                    if (sie_evt.setup_valid && ep_type_ff[i][ueh_pkg::TYPE_CTRL]) begin
                        nxt_st = ueh_pkg::RST_EP_STATUS;
                        nxt_st[ueh_pkg::BIT_SETUP] = 1'b1;
                    end
                end
                ep_status_ff[i] <= nxt_st;
            end
        end
    end

    // ==========================================================
    // Handshake answers for the endpoint the engine is serving
    always_comb begin
        logic [7:0] st;
        st = ep_status_ff[query_ep];
        hs.reject_out_b1 = st[ueh_pkg::BIT_OUT_B1] && !ep_type_ff[query_ep][ueh_pkg::TYPE_ISO];
        hs.send_stall = st[ueh_pkg::BIT_STALL_RQ];
        hs.in_ready = st[ueh_pkg::BIT_IN_RDY];
        hs.send_zlp = st[ueh_pkg::BIT_IN_RDY] && fifo_empty;
    end

    // ==========================================================
    // Interrupt: sticky per endpoint, write one to clear, masked
    always_comb begin
        evt_ep_hot = '0;
        for (int i = 0; i < ueh_pkg::NUM_EP; i++) begin
            // Stall sent is ignored on isochronous endpoints, so it raises nothing there
            if (sie_evt.ep == i[2:0] &&
                (sie_evt.out_b1_stored ||
                 (sie_evt.stall_sent && !ep_type_ff[i][ueh_pkg::TYPE_ISO]) ||
                 (sie_evt.setup_valid && ep_type_ff[i][ueh_pkg::TYPE_CTRL]))) begin
                evt_ep_hot[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_ff <= ueh_pkg::RST_IRQ;
        end else begin
            logic [5:0] clr;
            clr = (wr_en && pstrb[0] && paddr == ueh_pkg::OFS_IRQ_STATUS) ? pwdata[5:0] : 6'h00;
            irq_status_ff <= (irq_status_ff & ~clr) | evt_ep_hot;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_ff <= ueh_pkg::RST_IRQ;
        end else if (wr_en && pstrb[0] && paddr == ueh_pkg::OFS_IRQ_MASK) begin
            irq_mask_ff <= pwdata[5:0];
        end
    end

    assign irq = |(irq_status_ff & irq_mask_ff);

    // ==========================================================
    // Checks
    sequence s_out_b1_evt;
        sie_evt.out_b1_stored && !sie_evt.setup_valid && sie_evt.ep == 3'h2;
    endsequence

    a_out_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        s_out_b1_evt |=> ep_status_ff[2][ueh_pkg::BIT_OUT_B1])
        else $error("bank one flag not set");

    a_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
        (s_out_b1_evt and irq_mask_ff[2]) |=> irq)
        else $error("interrupt not raised");

    a_out_reject: assert property (@(posedge pclk) disable iff (!presetn)
        (query_ep == 3'h2 && ep_status_ff[2][ueh_pkg::BIT_OUT_B1] &&
         !ep_type_ff[2][ueh_pkg::TYPE_ISO]) |-> hs.reject_out_b1)
        else $error("bank one not rejected");

    a_iso_accept: assert property (@(posedge pclk) disable iff (!presetn)
        (query_ep == 3'h1 && ep_type_ff[1][ueh_pkg::TYPE_ISO]) |-> !hs.reject_out_b1)
        else $error("isochronous rejected");

    a_stall_answer: assert property (@(posedge pclk) disable iff (!presetn)
        (query_ep == 3'h0 && ep_status_ff[0][ueh_pkg::BIT_STALL_RQ]) |-> hs.send_stall)
        else $error("stall not requested");

    a_setup_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (sie_evt.setup_valid && sie_evt.ep == 3'h0 && ep_type_ff[0][ueh_pkg::TYPE_CTRL])
        |=> ep_status_ff[0] == 8'h04)
        else $error("setup did not clear status");

    a_zlp_send: assert property (@(posedge pclk) disable iff (!presetn)
        (query_ep == 3'h4 && ep_status_ff[4][ueh_pkg::BIT_IN_RDY] && fifo_empty)
        |-> hs.send_zlp)
        else $error("zero length packet missing");

    a_in_ack_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (sie_evt.in_acked && sie_evt.ep == 3'h4 && !(wr_en && ep_sel))
        |=> !ep_status_ff[4][ueh_pkg::BIT_IN_RDY])
        else $error("in ready not cleared");

    a_stall_sent: assert property (@(posedge pclk) disable iff (!presetn)
        (sie_evt.stall_sent && sie_evt.ep == 3'h0 && !sie_evt.setup_valid &&
         !ep_type_ff[0][ueh_pkg::TYPE_ISO]) |=> ep_status_ff[0][ueh_pkg::BIT_STALL_SENT])
        else $error("stall sent flag not set");

    // ==========================================================
    // Further checks on the endpoints the bench exercises
    // The checks above and below pin fixed endpoints on purpose: the
    // bench gives each endpoint one role, so every antecedent is reached.
    // A control SETUP aimed at endpoint 0, whatever other event comes beside it
    sequence s_ctrl_setup;
        sie_evt.setup_valid && sie_evt.ep == 3'h0 && ep_type_ff[0][ueh_pkg::TYPE_CTRL];
    endsequence

    a_setup_stall_drop: assert property (@(posedge pclk) disable iff (!presetn)
        s_ctrl_setup |=> !ep_status_ff[0][ueh_pkg::BIT_STALL_RQ])
        else $error("stall request survived setup");

    a_setup_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        s_ctrl_setup |=> ep_status_ff[0][ueh_pkg::BIT_SETUP])
        else $error("setup flag not set");

    a_setup_refused: assert property (@(posedge pclk) disable iff (!presetn)
        (sie_evt.setup_valid && sie_evt.ep == 3'h3 && !ep_type_ff[3][ueh_pkg::TYPE_CTRL] &&
         !sie_evt.out_b1_stored && !sie_evt.in_acked && !sie_evt.stall_sent && !wr_en)
        |=> $stable(ep_status_ff[3]))
        else $error("setup changed a non-control endpoint");

    a_out_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (ep_status_ff[2][ueh_pkg::BIT_OUT_B1] && !wr_en && !sie_evt.setup_valid)
        |=> ep_status_ff[2][ueh_pkg::BIT_OUT_B1])
        else $error("bank one flag dropped by itself");

    a_reject_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (query_ep == 3'h2 && !ep_status_ff[2][ueh_pkg::BIT_OUT_B1]) |-> !hs.reject_out_b1)
        else $error("bank one refused while free");

    a_stall_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (query_ep == 3'h0 && !ep_status_ff[0][ueh_pkg::BIT_STALL_RQ]) |-> !hs.send_stall)
        else $error("stall without request");

    // data present means no empty packet
    a_zlp_full: assert property (@(posedge pclk) disable iff (!presetn)
        (query_ep == 3'h4 && !fifo_empty) |-> !hs.send_zlp)
        else $error("empty packet with data present");

    a_out_irq_set: assert property (@(posedge pclk) disable iff (!presetn)
        s_out_b1_evt |=> irq_status_ff[2])
        else $error("interrupt status not set");

    a_irq_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_status_ff[2] && !wr_en) |=> irq_status_ff[2])
        else $error("interrupt status lost");

    a_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && pstrb[0] && paddr == ueh_pkg::OFS_IRQ_STATUS && pwdata[5] &&
         sie_evt.ep != 3'h5) |=> !irq_status_ff[5])
        else $error("interrupt status not cleared");

    // with every source masked the line stays low
    a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_mask_ff == 6'h00) |-> !irq)
        else $error("interrupt while fully masked");

    // stall sent also marks the endpoint
    a_stall_irq: assert property (@(posedge pclk) disable iff (!presetn)
        (sie_evt.stall_sent && sie_evt.ep == 3'h0 && !ep_type_ff[0][ueh_pkg::TYPE_ISO])
        |=> irq_status_ff[0])
        else $error("stall sent not flagged");

    // one endpoint's event leaves another alone
    a_ep_indep: assert property (@(posedge pclk) disable iff (!presetn)
        (s_out_b1_evt and !wr_en) |=> $stable(ep_status_ff[3]))
        else $error("event leaked to another endpoint");

    a_slverr_map: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && paddr == ueh_pkg::OFS_IRQ_MASK) |-> !pslverr)
        else $error("error on a mapped register");
endmodule

/* tb/ueh_sie_model.sv */
/*
 * Stand-in for the serial engine that faces the USB host: one-cycle
 * packet events and the endpoint handshake query.
 * Assumes it shares pclk with the status block; events change after an edge.
 */
`timescale 1ns/1ps
module ueh_sie_model (
    input wire logic pclk,
    output ueh_pkg::ueh_sie_evt_s sie_evt,
    output logic [2:0] query_ep,
    output logic fifo_empty
);
    // ==========================================================
    // Idle bus: no event and a neutral query
    initial begin
        sie_evt = '0;
        query_ep = 3'h0;
        fifo_empty = 1'b0;
    end

    // One event pulse; kind is {out, setup, ack, stall sent}
    task automatic pulse(input logic [3:0] kind, input logic [2:0] ep);
        @(posedge pclk);
        sie_evt <= {kind, ep};
        @(posedge pclk);
        sie_evt <= '0;
    endtask

    // Points the handshake query at one endpoint
    task automatic ask(input logic [2:0] ep, input logic empty);
        @(posedge pclk);
        query_ep <= ep;
        fifo_empty <= empty;
    endtask
endmodule

/* tb/usb_endpoint_handshake_status_tb.sv */
/*
 * Self-checking bench for the endpoint handshake status block.
 * Assumes APB answers with pready; expectations queue beside the driver.
 */
`timescale 1ns/1ps
module usb_endpoint_handshake_status_tb;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, irq, fifo_empty;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb;
    logic [2:0] query_ep;
    ueh_pkg::ueh_sie_evt_s sie_evt;
    ueh_pkg::ueh_hs_s hs;
    logic [32:0] exp_q[$];
    int failures = 0;
    int n_checks = 0;

    // ==========================================================
    // Clock and instances
    always #10 pclk = ~pclk;
    ueh_status u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sie_evt(sie_evt), .query_ep(query_ep),
        .fifo_empty(fifo_empty), .hs(hs), .irq(irq));
    ueh_sie_model u_sie (.pclk(pclk), .sie_evt(sie_evt), .query_ep(query_ep),
        .fifo_empty(fifo_empty));

    // ==========================================================
    // Comparison and verdict
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        if (failures == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // APB master: holds the request until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        exp_q.push_back(e);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, {1'b0, e});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0_0000_0000);
    endtask
    // Query one endpoint and compare {irq, hs} once settled
    task automatic hsc(input logic [2:0] ep, input logic empty, input logic [4:0] e);
        u_sie.ask(ep, empty);
        @(negedge pclk);
        chk({28'h0, irq, hs}, {28'h0, e});
    endtask

    // Monitor: each completed transfer retires the oldest expectation
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            chk({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
        end
    end

    // Watchdog, far beyond the 150 or so cycles the run needs
    initial begin
        #200000;
        failures++;
        summarize();
    end

    // ==========================================================
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        pstrb = 4'hf;
        void'($urandom(32'hca77));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) rd(12'(4 * i), 32'h0000_0000);
        rd(ueh_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
        rd(ueh_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        wr(ueh_pkg::OFS_EP_TYPE, 32'h0000_0001);
        wr(ueh_pkg::OFS_EP_TYPE + 12'h004, 32'h0000_0002);
        wr(ueh_pkg::OFS_IRQ_MASK, 32'h0000_003f);
        r = $urandom;
        wr(12'h00c, {24'h0, r[7:0]});
        rd(12'h00c, {24'h0, r[7:0]});
        rd(12'h010, 32'h0000_0000);
        // Bank-one OUT: flag, interrupt, refusal until firmware clears
        u_sie.pulse(4'b1000, 3'h2);
        hsc(3'h2, 1'b0, 5'b1_1000);
        rd(12'h008, 32'h0000_0040);
        rd(ueh_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
        wr(ueh_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
        hsc(3'h2, 1'b0, 5'b0_1000);
        wr(12'h008, 32'h0000_0000);
        hsc(3'h2, 1'b0, 5'b0_0000);
        // Isochronous endpoint is never refused
        u_sie.pulse(4'b1000, 3'h1);
        hsc(3'h1, 1'b0, 5'b1_0000);
        rd(12'h004, 32'h0000_0040);
        wr(12'h004, 32'h0000_0000);
        // Masked source: sticky bit without the line
        wr(ueh_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        wr(ueh_pkg::OFS_IRQ_STATUS, 32'h0000_003f);
        u_sie.pulse(4'b1000, 3'h5);
        hsc(3'h5, 1'b0, 5'b0_1000);
        rd(ueh_pkg::OFS_IRQ_STATUS, 32'h0000_0020);
        wr(ueh_pkg::OFS_IRQ_MASK, 32'h0000_0020);
        hsc(3'h5, 1'b0, 5'b1_1000);
        wr(12'h014, 32'h0000_0000);
        wr(ueh_pkg::OFS_IRQ_STATUS, 32'h0000_0020);
        // Stall request, stall sent, then SETUP clears the word but for its own flag
        wr(12'h000, 32'h0000_0020);
        hsc(3'h0, 1'b0, 5'b0_0100);
        u_sie.pulse(4'b0001, 3'h0);
        rd(12'h000, 32'h0000_0028);
        u_sie.pulse(4'b0100, 3'h0);
        rd(12'h000, 32'h0000_0004);
        hsc(3'h0, 1'b0, 5'b0_0000);
        u_sie.pulse(4'b0100, 3'h3);
        rd(12'h00c, {24'h0, r[7:0]});
        // IN ready, zero-length answer, cleared on acknowledge
        wr(12'h010, 32'h0000_0010);
        hsc(3'h4, 1'b1, 5'b0_0011);
        hsc(3'h4, 1'b0, 5'b0_0010);
        u_sie.pulse(4'b0010, 3'h4);
        rd(12'h010, 32'h0000_0000);
        // Unmapped place answers with an error
        apb(1'b0, 12'h0fc, 32'h0000_0000, 33'h1_0000_0000);
        apb(1'b1, 12'h0fc, 32'h0000_00ff, 33'h1_0000_0000);
        repeat (2) @(posedge pclk);
        summarize();
    end
endmodule
